// ==== rtl/fan_zone_pkg.sv ====
package fan_zone_pkg;

    // data widths and reading count
    localparam int          TEMP_W          = 8;
    localparam int          NUM_READINGS    = 10;
    localparam int          CODE_W          = 4;

    // register offsets
    localparam logic [7:0]  REG_CONFIG_TWO  = 8'h74;
    localparam logic [7:0]  REG_HOTTEST     = 8'h78;
    localparam logic [7:0]  REG_FAN12       = 8'h7C;
    localparam logic [7:0]  REG_FAN34       = 8'h7D;

    // reset values
    localparam logic [7:0]  RST_CONFIG_TWO  = 8'h00;
    localparam logic [7:0]  RST_HOTTEST     = 8'h00;
    localparam logic [7:0]  RST_FAN12       = 8'h00;
    localparam logic [7:0]  RST_FAN34       = 8'h00;
    localparam logic [7:0]  RST_TEMP_OUT    = 8'h00;
    localparam logic [7:0]  UNMAPPED_READ   = 8'h00;

    // field positions inside a source-select register
    localparam int          HI_CODE_LSB     = 4;
    localparam int          LO_CODE_LSB     = 0;

    // source-select code meanings
    localparam logic [3:0]  SRC_HOTTEST     = 4'h0;
    localparam logic [3:0]  SRC_FIRST       = 4'h1;
    localparam logic [3:0]  SRC_LAST        = 4'hA;

    // serial bus framing
    localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;
    localparam logic [6:0]  DEFAULT_DEV_ADR = 7'h2E;

    typedef enum logic [3:0] {
        ST_IDLE      = 4'b0000,
        ST_ADDR      = 4'b0001,
        ST_ADDR_ACK  = 4'b0010,
        ST_PTR       = 4'b0011,
        ST_PTR_ACK   = 4'b0100,
        ST_WDATA     = 4'b0101,
        ST_WDATA_ACK = 4'b0110,
        ST_RDATA     = 4'b0111,
        ST_RDATA_ACK = 4'b1000
    } bus_state_e;

endpackage : fan_zone_pkg

// ==== rtl/fan_source_mux.sv ====
`timescale 1ns/1ps
module fan_source_mux (
    input  wire logic                                                   i_mclk,
    input  wire logic                                                   i_rstn,
    input  wire logic [fan_zone_pkg::CODE_W-1:0]                        i_code,
    input  wire logic [fan_zone_pkg::TEMP_W-1:0]                        i_hottest,
    input  wire logic [fan_zone_pkg::NUM_READINGS*fan_zone_pkg::TEMP_W-1:0] i_readings,
    output logic      [fan_zone_pkg::TEMP_W-1:0]                        o_temp
);

    typedef struct packed {
        logic [fan_zone_pkg::TEMP_W-1:0] temp;
    } mux_state_s;

    mux_state_s st_q;
    mux_state_s st_d;

    always_comb begin
        st_d = st_q;
        if (i_code >= fan_zone_pkg::SRC_FIRST && i_code <= fan_zone_pkg::SRC_LAST) begin
            // code n picks reading n, readings packed from the first one upward
            st_d.temp = i_readings[(32'(i_code) - 1) * fan_zone_pkg::TEMP_W +: fan_zone_pkg::TEMP_W];
        end else begin
            // zero, and the undefined codes above ten, fall back to the hottest sensor
            st_d.temp = i_hottest;
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_q.temp <= fan_zone_pkg::RST_TEMP_OUT;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_temp = st_q.temp;

endmodule : fan_source_mux

// ==== rtl/fan_zone_source_select.sv ====
`timescale 1ns/1ps
// Overview of operation
// - read-only register holds hottest remote reading
// - first select bits 7:4 pick fan 1
// - first select bits 3:0 pick fan 2
// - second select bits 7:4 pick fan 3
// - second select bits 3:0 pick fan 4
// - code zero feeds fan from hottest reading
// - codes one to ten pick that reading
// - code ten picks the tenth reading
// - second select follows first, resets zero
module fan_zone_source_select #(
    parameter logic [6:0] DEV_ADR = fan_zone_pkg::DEFAULT_DEV_ADR
) (
    input  wire logic                                                   i_mclk,
    input  wire logic                                                   i_rstn,
    input  wire logic                                                   i_scl,
    input  wire logic                                                   i_sda,
    output logic                                                        o_sda_o,
    output logic                                                        o_sda_oe,
    input  wire logic [fan_zone_pkg::NUM_READINGS*fan_zone_pkg::TEMP_W-1:0] i_readings,
    output logic      [7:0]                                             o_config_two,
    output logic      [fan_zone_pkg::TEMP_W-1:0]                        o_fan1_temp,
    output logic      [fan_zone_pkg::TEMP_W-1:0]                        o_fan2_temp,
    output logic      [fan_zone_pkg::TEMP_W-1:0]                        o_fan3_temp,
    output logic      [fan_zone_pkg::TEMP_W-1:0]                        o_fan4_temp
);

    typedef struct packed {
        logic                           scl_m;
        logic                           scl_s;
        logic                           scl_p;
        logic                           sda_m;
        logic                           sda_s;
        logic                           sda_p;
        fan_zone_pkg::bus_state_e       state;
        logic [3:0]                     bitcnt;
        logic [7:0]                     shift;
        logic [7:0]                     tx;
        logic [7:0]                     ptr;
        logic                           rw;
        logic                           nack;
        logic                           sda_o;
        logic                           sda_oe;
        logic [7:0]                     config_two;
        logic [7:0]                     hottest;
        logic [7:0]                     fan12;
        logic [7:0]                     fan34;
    } top_state_s;

    top_state_s st_q;
    top_state_s st_d;

    logic       scl_rise;
    logic       scl_fall;
    logic       start_seen;
    logic       stop_seen;
    logic [7:0] rd_data;
    logic [7:0] rd_next_ptr;
    logic [7:0] max_now;

    // only the second sync stage and its delayed copy feed the edge logic
    assign scl_rise   = st_q.scl_s & ~st_q.scl_p;
    assign scl_fall   = ~st_q.scl_s & st_q.scl_p;
    assign start_seen = st_q.scl_s & st_q.scl_p & st_q.sda_p & ~st_q.sda_s;
    assign stop_seen  = st_q.scl_s & st_q.scl_p & ~st_q.sda_p & st_q.sda_s;

    // largest of all current remote readings
    always_comb begin
        max_now = '0;
        for (int i = 0; i < fan_zone_pkg::NUM_READINGS; i++) begin
            if (i_readings[i*fan_zone_pkg::TEMP_W +: fan_zone_pkg::TEMP_W] > max_now) begin
                max_now = i_readings[i*fan_zone_pkg::TEMP_W +: fan_zone_pkg::TEMP_W];
            end
        end
    end

    // read decode at the current pointer; unmapped offsets read as zero
    always_comb begin
        case (st_q.ptr)
            fan_zone_pkg::REG_CONFIG_TWO: rd_data = st_q.config_two;
            fan_zone_pkg::REG_HOTTEST:    rd_data = st_q.hottest;
            fan_zone_pkg::REG_FAN12:      rd_data = st_q.fan12;
            fan_zone_pkg::REG_FAN34:      rd_data = st_q.fan34;
            default:                      rd_data = fan_zone_pkg::UNMAPPED_READ;
        endcase
    end

    assign rd_next_ptr = st_q.ptr + 8'h01;

    always_comb begin
        st_d       = st_q;
        st_d.scl_m = i_scl;
        st_d.scl_s = st_q.scl_m;
        st_d.scl_p = st_q.scl_s;
        st_d.sda_m = i_sda;
        st_d.sda_s = st_q.sda_m;
        st_d.sda_p = st_q.sda_s;
        // refreshed every cycle so it always tracks the sensors; no write path
        st_d.hottest = max_now;
        st_d.sda_o   = 1'b0;

        if (start_seen) begin
            // a repeated start keeps the pointer so a read can follow a pointer write
            st_d.state  = fan_zone_pkg::ST_ADDR;
            st_d.bitcnt = '0;
            st_d.sda_oe = 1'b0;
        end else if (stop_seen) begin
            st_d.state  = fan_zone_pkg::ST_IDLE;
            st_d.sda_oe = 1'b0;
        end else begin
            case (st_q.state)
                fan_zone_pkg::ST_IDLE: begin
                    st_d.sda_oe = 1'b0;
                end
                fan_zone_pkg::ST_ADDR: begin
                    if (scl_rise) begin
                        st_d.shift  = {st_q.shift[6:0], st_q.sda_s};
                        st_d.bitcnt = st_q.bitcnt + 4'h1;
                    end else if (scl_fall && st_q.bitcnt == fan_zone_pkg::BITS_PER_BYTE) begin
                        if (st_q.shift[7:1] == DEV_ADR) begin
                            st_d.rw     = st_q.shift[0];
                            st_d.sda_oe = 1'b1;
                            st_d.state  = fan_zone_pkg::ST_ADDR_ACK;
                        end else begin
                            st_d.state  = fan_zone_pkg::ST_IDLE;
                        end
                    end
                end
                fan_zone_pkg::ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        st_d.bitcnt = '0;
                        if (st_q.rw) begin
                            st_d.tx     = rd_data;
                            st_d.sda_oe = ~rd_data[7];
                            st_d.ptr    = rd_next_ptr;
                            st_d.state  = fan_zone_pkg::ST_RDATA;
                        end else begin
                            st_d.sda_oe = 1'b0;
                            st_d.state  = fan_zone_pkg::ST_PTR;
                        end
                    end
                end
                fan_zone_pkg::ST_PTR: begin
                    if (scl_rise) begin
                        st_d.shift  = {st_q.shift[6:0], st_q.sda_s};
                        st_d.bitcnt = st_q.bitcnt + 4'h1;
                    end else if (scl_fall && st_q.bitcnt == fan_zone_pkg::BITS_PER_BYTE) begin
                        st_d.ptr    = st_q.shift;
                        st_d.sda_oe = 1'b1;
                        st_d.state  = fan_zone_pkg::ST_PTR_ACK;
                    end
                end
                fan_zone_pkg::ST_PTR_ACK, fan_zone_pkg::ST_WDATA_ACK: begin
                    if (scl_fall) begin
                        st_d.sda_oe = 1'b0;
                        st_d.bitcnt = '0;
                        st_d.state  = fan_zone_pkg::ST_WDATA;
                    end
                end
                fan_zone_pkg::ST_WDATA: begin
                    if (scl_rise) begin
                        st_d.shift  = {st_q.shift[6:0], st_q.sda_s};
                        st_d.bitcnt = st_q.bitcnt + 4'h1;
                    end else if (scl_fall && st_q.bitcnt == fan_zone_pkg::BITS_PER_BYTE) begin
                        case (st_q.ptr)
                            fan_zone_pkg::REG_CONFIG_TWO: st_d.config_two = st_q.shift;
                            // whole byte stored, undefined codes included, so it reads back
                            fan_zone_pkg::REG_FAN12:      st_d.fan12 = st_q.shift;
                            fan_zone_pkg::REG_FAN34:      st_d.fan34 = st_q.shift;
                            // the hottest reading and unmapped offsets drop the byte
                            default:                      st_d.config_two = st_q.config_two;
                        endcase
                        // the byte is still acknowledged so the master sees no error
                        st_d.ptr    = rd_next_ptr;
                        st_d.sda_oe = 1'b1;
                        st_d.state  = fan_zone_pkg::ST_WDATA_ACK;
                    end
                end
                fan_zone_pkg::ST_RDATA: begin
                    if (scl_rise) begin
                        st_d.bitcnt = st_q.bitcnt + 4'h1;
                    end else if (scl_fall) begin
                        if (st_q.bitcnt == fan_zone_pkg::BITS_PER_BYTE) begin
                            st_d.sda_oe = 1'b0;
                            st_d.state  = fan_zone_pkg::ST_RDATA_ACK;
                        end else begin
                            st_d.tx     = {st_q.tx[6:0], 1'b0};
                            st_d.sda_oe = ~st_q.tx[6];
                        end
                    end
                end
                fan_zone_pkg::ST_RDATA_ACK: begin
                    if (scl_rise) begin
                        st_d.nack = st_q.sda_s;
                    end else if (scl_fall) begin
                        if (st_q.nack) begin
                            st_d.state  = fan_zone_pkg::ST_IDLE;
                        end else begin
                            st_d.bitcnt = '0;
                            st_d.tx     = rd_data;
                            st_d.sda_oe = ~rd_data[7];
                            st_d.ptr    = rd_next_ptr;
                            st_d.state  = fan_zone_pkg::ST_RDATA;
                        end
                    end
                end
                default: begin
                    st_d.state  = fan_zone_pkg::ST_IDLE;
                    st_d.sda_oe = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            // bus lines idle high, so the sync stages reset high to avoid a false start
            st_q.scl_m      <= 1'b1;
            st_q.scl_s      <= 1'b1;
            st_q.scl_p      <= 1'b1;
            st_q.sda_m      <= 1'b1;
            st_q.sda_s      <= 1'b1;
            st_q.sda_p      <= 1'b1;
            st_q.state      <= fan_zone_pkg::ST_IDLE;
            st_q.bitcnt     <= '0;
            st_q.shift      <= '0;
            st_q.tx         <= '0;
            st_q.ptr        <= '0;
            st_q.rw         <= 1'b0;
            st_q.nack       <= 1'b0;
            st_q.sda_o      <= 1'b0;
            st_q.sda_oe     <= 1'b0;
            st_q.config_two <= fan_zone_pkg::RST_CONFIG_TWO;
            st_q.hottest    <= fan_zone_pkg::RST_HOTTEST;
            st_q.fan12      <= fan_zone_pkg::RST_FAN12;
            st_q.fan34      <= fan_zone_pkg::RST_FAN34;
        end else begin
            st_q <= st_d;
        end
    end

    assign o_sda_o      = st_q.sda_o;
    assign o_sda_oe     = st_q.sda_oe;
    assign o_config_two = st_q.config_two;

    // one registered selector per fan; one cycle of latency after a code or selected-reading change, two via the hottest register
    fan_source_mux u_fan1 (
        .i_mclk     (i_mclk),
        .i_rstn     (i_rstn),
        .i_code     (st_q.fan12[fan_zone_pkg::HI_CODE_LSB +: fan_zone_pkg::CODE_W]),
        .i_hottest  (st_q.hottest),
        .i_readings (i_readings),
        .o_temp     (o_fan1_temp)
    );

    fan_source_mux u_fan2 (
        .i_mclk     (i_mclk),
        .i_rstn     (i_rstn),
        .i_code     (st_q.fan12[fan_zone_pkg::LO_CODE_LSB +: fan_zone_pkg::CODE_W]),
        .i_hottest  (st_q.hottest),
        .i_readings (i_readings),
        .o_temp     (o_fan2_temp)
    );

    fan_source_mux u_fan3 (
        .i_mclk     (i_mclk),
        .i_rstn     (i_rstn),
        .i_code     (st_q.fan34[fan_zone_pkg::HI_CODE_LSB +: fan_zone_pkg::CODE_W]),
        .i_hottest  (st_q.hottest),
        .i_readings (i_readings),
        .o_temp     (o_fan3_temp)
    );

    fan_source_mux u_fan4 (
        .i_mclk     (i_mclk),
        .i_rstn     (i_rstn),
        .i_code     (st_q.fan34[fan_zone_pkg::LO_CODE_LSB +: fan_zone_pkg::CODE_W]),
        .i_hottest  (st_q.hottest),
        .i_readings (i_readings),
        .o_temp     (o_fan4_temp)
    );

endmodule : fan_zone_source_select

// ==== bench/fan_zone_source_select_props.sv ====
`timescale 1ns/1ps
module fan_zone_source_select_props (
    input wire logic        i_mclk,
    input wire logic        i_rstn,
    input wire logic        i_scl,
    input wire logic        i_sda,
    input wire logic        o_sda_o,
    input wire logic        o_sda_oe,
    input wire logic [79:0] i_readings,
    input wire logic [7:0]  o_config_two,
    input wire logic [7:0]  o_fan1_temp,
    input wire logic [7:0]  o_fan2_temp,
    input wire logic [7:0]  o_fan3_temp,
    input wire logic [7:0]  o_fan4_temp
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    logic [7:0]  max_now;
    logic [7:0]  max_q;
    logic [7:0]  max_qq;
    logic [79:0] read_q;
    logic        acked_q;
    always_comb begin
        max_now = 8'h00;
        for (int n = 0; n < 10; n++) begin
            max_now = (i_readings[n*8 +: 8] > max_now) ? i_readings[n*8 +: 8] : max_now;
        end
    end
    // max_qq lines up with the two-stage hottest path behind the fan outputs, read_q with the one-stage reading path
    always_ff @(posedge i_mclk or negedge i_rstn) begin
        if (!i_rstn) begin
            max_q   <= 8'h00;
            max_qq  <= 8'h00;
            read_q  <= 80'h0;
            acked_q <= 1'h0;
        end else begin
            max_q   <= max_now;
            max_qq  <= max_q;
            read_q  <= i_readings;
            acked_q <= acked_q | o_sda_oe;
        end
    end
    // references passed in, so they are sampled at the same edge as the output
    function automatic logic legal(input logic [7:0] v, input logic [7:0] m, input logic [79:0] r);
        legal = (v == m);
        for (int n = 0; n < 10; n++) begin
            legal = legal | (v == r[n*8 +: 8]);
        end
    endfunction : legal
    // before any acknowledge no code can have been written
    property p_fan1_default; !acked_q |-> o_fan1_temp == max_qq; endproperty
    a_fan1_default: assert property (p_fan1_default)
        else $error("fan 1 not on hottest after reset");
    property p_fan2_default; !acked_q |-> o_fan2_temp == max_qq; endproperty
    a_fan2_default: assert property (p_fan2_default)
        else $error("fan 2 not on hottest after reset");
    property p_fan3_default; !acked_q |-> o_fan3_temp == max_qq; endproperty
    a_fan3_default: assert property (p_fan3_default)
        else $error("fan 3 not on hottest after reset");
    property p_fan4_default; !acked_q |-> o_fan4_temp == max_qq; endproperty
    a_fan4_default: assert property (p_fan4_default)
        else $error("fan 4 not on hottest after reset");
    property p_fan1_legal; acked_q |-> legal(o_fan1_temp, max_qq, read_q); endproperty
    a_fan1_legal: assert property (p_fan1_legal)
        else $error("fan 1 shows no known reading");
    property p_fan2_legal; acked_q |-> legal(o_fan2_temp, max_qq, read_q); endproperty
    a_fan2_legal: assert property (p_fan2_legal)
        else $error("fan 2 shows no known reading");
    property p_fan3_legal; acked_q |-> legal(o_fan3_temp, max_qq, read_q); endproperty
    a_fan3_legal: assert property (p_fan3_legal)
        else $error("fan 3 shows no known reading");
    property p_fan4_legal; acked_q |-> legal(o_fan4_temp, max_qq, read_q); endproperty
    a_fan4_legal: assert property (p_fan4_legal)
        else $error("fan 4 shows no known reading");
    c_fan1_moved: cover property (acked_q && o_fan1_temp != max_qq);
    c_fan2_tenth: cover property (o_fan2_temp == read_q[79:72] && o_fan2_temp != max_qq);
    c_cfg_write: cover property ($changed(o_config_two));
endmodule : fan_zone_source_select_props

bind fan_zone_source_select fan_zone_source_select_props u_props (.*);

// ==== bench/smbus_host_model.sv ====
`timescale 1ns/1ps
module smbus_host_model #(
    parameter logic [6:0] DEV = 7'h2E
) (
    input  wire logic i_mclk,
    input  wire logic i_sda,
    output logic      o_scl,
    output logic      o_sda
);
    initial begin
        o_scl = 1'h1;
        o_sda = 1'h1;
    end
    task automatic wait_mclk(input int n);
        repeat (n) @(posedge i_mclk);
    endtask : wait_mclk
    // start is frame(1,0), stop is frame(0,1); data never moves on the clock edge itself
    task automatic frame(input logic a, input logic b);
        wait_mclk(4);
        o_sda <= a;
        wait_mclk(4);
        o_scl <= 1'h1;
        wait_mclk(8);
        o_sda <= b;
        wait_mclk(8);
        o_scl <= b;
    endtask : frame
    task automatic put_bit(input logic b, output logic got);
        wait_mclk(4);
        o_sda <= b;
        wait_mclk(4);
        o_scl <= 1'h1;
        wait_mclk(8);
        got = i_sda;
        o_scl <= 1'h0;
    endtask : put_bit
    task automatic put_byte(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            put_bit(tx[i], rx[i]);
        end
        put_bit(ack_in, ack);
    endtask : put_byte
    task automatic write_regs(input logic [7:0] ptr, input logic [15:0] data, input int n, output logic nack);
        logic [7:0] rx;
        logic       a;
        frame(1'h1, 1'h0);
        put_byte({DEV, 1'h0}, 1'h1, rx, nack);
        put_byte(ptr, 1'h1, rx, a);
        nack = nack | a;
        for (int i = n - 1; i >= 0; i--) begin
            put_byte(data[i*8 +: 8], 1'h1, rx, a);
            nack = nack | a;
        end
        frame(1'h0, 1'h1);
    endtask : write_regs
    task automatic read_regs(input logic [7:0] ptr, input int n, output logic [15:0] data, output logic nack);
        logic [7:0] rx;
        logic       a;
        data = 16'h0000;
        frame(1'h1, 1'h0);
        put_byte({DEV, 1'h0}, 1'h1, rx, nack);
        put_byte(ptr, 1'h1, rx, a);
        nack = nack | a;
        frame(1'h1, 1'h0);
        put_byte({DEV, 1'h1}, 1'h1, rx, a);
        nack = nack | a;
        for (int i = n - 1; i >= 0; i--) begin
            put_byte(8'hFF, 1'(i == 0), rx, a);
            data[i*8 +: 8] = rx;
        end
        frame(1'h0, 1'h1);
    endtask : read_regs
endmodule : smbus_host_model

// ==== bench/fan_zone_source_select_tb_top.sv ====
`timescale 1ns/1ps
module fan_zone_source_select_tb_top;
    logic            i_mclk;
    logic            i_rstn;
    logic            scl;
    logic            host_sda;
    logic            sda_oe;
    logic [79:0]     readings;
    logic [7:0]      cfg;
    wire  [3:0][7:0] fan;
    logic [7:0]      rd [1:10];
    logic [15:0]     got;
    logic [15:0]     codes;
    logic            nack;
    int              err_count;
    int              n_compared;
    wire             sda_line = sda_oe ? 1'h0 : host_sda;
    fan_zone_source_select uut (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_scl(scl), .i_sda(sda_line),
        .o_sda_o(), .o_sda_oe(sda_oe), .i_readings(readings), .o_config_two(cfg),
        .o_fan1_temp(fan[0]), .o_fan2_temp(fan[1]), .o_fan3_temp(fan[2]), .o_fan4_temp(fan[3]));
    smbus_host_model u_host (.i_mclk(i_mclk), .i_sda(sda_line), .o_scl(scl), .o_sda(host_sda));
    always #4 i_mclk = ~i_mclk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : summarize
    function automatic logic [7:0] hottest();
        hottest = 8'h00;
        for (int n = 1; n <= 10; n++) begin
            hottest = (rd[n] > hottest) ? rd[n] : hottest;
        end
    endfunction : hottest
    // codes above ten fall back to the hottest reading
    function automatic logic [7:0] exp_fan(input logic [3:0] c);
        return (c >= 4'h1 && c <= 4'hA) ? rd[c] : hottest();
    endfunction : exp_fan
    task automatic drive_readings();
        logic [79:0] v;
        for (int n = 1; n <= 10; n++) begin
            v[n*8-8 +: 8] = rd[n];
        end
        @(posedge i_mclk);
        readings <= v;
        repeat (4) @(posedge i_mclk);
    endtask : drive_readings
    task automatic check_fans(input logic [15:0] c);
        for (int f = 0; f < 4; f++) begin
            check(16'(fan[f]), 16'(exp_fan(c[15-4*f -: 4])));
        end
    endtask : check_fans
    initial begin
        i_mclk = 1'h0;
        i_rstn = 1'h0;
        readings = 80'h0;
        err_count = 0;
        n_compared = 0;
        for (int n = 1; n <= 10; n++) begin
            rd[n] = {n[3:0], n[3:0]};
        end
        rd[6] = 8'hF0;
        repeat (3) @(posedge i_mclk);
        i_rstn <= 1'h1;
        drive_readings();
        check_fans(16'h0000);
        u_host.read_regs(8'h7C, 2, got, nack);
        check(got, 16'h0000);
        u_host.read_regs(8'h77, 2, got, nack);
        check(got, {8'h00, hottest()});
        for (int c = 0; c < 16; c++) begin
            codes = {c[3:0], c[3:0] + 4'h5, c[3:0] + 4'hA, ~c[3:0]};
            u_host.write_regs(8'h7C, codes, 2, nack);
            check(16'(nack), 16'h0000);
            check_fans(codes);
            u_host.read_regs(8'h7C, 2, got, nack);
            check(got, codes);
        end
        rd[3] = 8'hFB;
        drive_readings();
        check_fans(codes);
        u_host.write_regs(8'h78, 16'h0012, 1, nack);
        u_host.read_regs(8'h77, 2, got, nack);
        check(got, 16'h00FB);
        u_host.write_regs(8'h74, 16'h005A, 1, nack);
        check(16'(cfg), 16'h005A);
        u_host.read_regs(8'h74, 1, got, nack);
        check(got, 16'h005A);
        summarize();
    end
    initial begin
        repeat (60000) @(posedge i_mclk);
        err_count++;
        summarize();
    end
endmodule : fan_zone_source_select_tb_top
